// ==== logic/ccm_pkg.sv ====
// constants shared by the configuration and mode controller
// assumes a single 20 MHz system clock
package ccm_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int PAGE_W = 64;
  localparam int NUM_PAGES = 4;
  localparam int SEL_WIN_US = 350;
  // longest time: round down
  localparam int SEL_WIN_CYC = (SEL_WIN_US * (CLK_HZ / 1000000));
  localparam int SETTLE_US = 1500;
  localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000));
  localparam int POWER_CYC_WAIT = 16;
  // boot waits out both synchroniser stages before sampling straps
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [1:0] LOAD_TAKE = 2'h1;
  localparam logic [1:0] LOAD_DONE = 2'h2;
  localparam logic [1:0] PAGE_ZERO = 2'h0;
  localparam logic [1:0] PAGE_TOP = 2'h3;
  localparam logic MODE_I2C = 1'h0;
  localparam logic MODE_PAGE = 1'h1;
  localparam int PWR_DOWN_BIT = 1;
  localparam int RELOAD_INH_BIT = 2;
  localparam int RESAMPLE_INH_BIT = 3;
  localparam int IDLE_SEL_BIT = 4;

  typedef enum logic [5:0] {
    CCM_BOOT = 6'h01,
    CCM_LOAD = 6'h02,
    CCM_RUN = 6'h04,
    CCM_LOWPWR = 6'h08,
    CCM_EXIT = 6'h10,
    CCM_SETTLE = 6'h20
  } ccm_state_t;

  function automatic logic [1:0] ccm_page_of(input logic sel1,
                                             input logic sel0);
    return {sel1, sel0};
  endfunction
endpackage

// ==== logic/ccm_sync2.sv ====
// two flip-flop synchroniser for a bus of pin levels
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module ccm_sync2 #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ==== logic/ccm_page_store.sv ====
// read-only fused page store, four pages of configuration bits
// contents fixed at build time; no write port exists
`timescale 1ns/1ps
`default_nettype none
module ccm_page_store #(
  parameter int W = 64,
  parameter logic [W-1:0] PAGE0 = '0,
  parameter logic [W-1:0] PAGE1 = '0,
  parameter logic [W-1:0] PAGE2 = '0,
  parameter logic [W-1:0] PAGE3 = '0
) (
  input wire logic clk_sys,
  input wire logic [1:0] page_idx,
  output logic [W-1:0] page_data
);
  logic [W-1:0] rom [0:3];
  logic [W-1:0] data_reg;
  assign rom[0] = PAGE0;
  assign rom[1] = PAGE1;
  assign rom[2] = PAGE2;
  assign rom[3] = PAGE3;
  always_ff @(posedge clk_sys) begin
    data_reg <= rom[page_idx];
  end
  assign page_data = data_reg;
endmodule
`default_nettype wire

// ==== logic/ccm_ctrl.sv ====
// configuration and mode controller: strap sampling, page loads, low power
// assumes pins are asynchronous, host register writes arrive on clk_sys
`timescale 1ns/1ps
`default_nettype none
module ccm_ctrl #(
  parameter int W = ccm_pkg::PAGE_W,
  parameter int SETTLE_CYCLES = ccm_pkg::SETTLE_CYC,
  parameter int WIN_CYCLES = ccm_pkg::SEL_WIN_CYC,
  parameter logic [W-1:0] PAGE0 = '0,
  parameter logic [W-1:0] PAGE1 = '0,
  parameter logic [W-1:0] PAGE2 = '0,
  parameter logic [W-1:0] PAGE3 = '0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mode_strap_pin,
  input wire logic addr_strap_pin,
  input wire logic page_select_bit0_pin,
  input wire logic page_select_bit1_pin,
  input wire logic host_wr,
  input wire logic [W-1:0] host_wdata,
  input wire logic power_down_request,
  input wire logic idle_on_outputs_off_sel,
  input wire logic page0_reload_inhibit,
  input wire logic strap_resample_inhibit,
  input wire logic outputs_disabled,
  output logic [W-1:0] active_cfg,
  output logic mode_page,
  output logic [1:0] active_page,
  output logic addr_lsb,
  output logic bus_enable,
  output logic bus_scl_in,
  output logic bus_sda_in,
  output logic low_power,
  output logic busy
);
  logic [3:0] pins_sync;
  logic strap_s, addr_s, sel0_s, sel1_s;
  logic [1:0] sel_page;
  logic [1:0] sel_prev_reg;
  logic strap_prev_reg;
  ccm_pkg::ccm_state_t state_reg, state_next;
  logic [W-1:0] cfg_reg;
  logic mode_reg;
  logic [1:0] page_reg;
  logic [1:0] load_page_reg, load_page_next;
  logic addr_reg;
  logic [W-1:0] rom_data;
  logic [$clog2(SETTLE_CYCLES+1)-1:0] cnt_reg;
  logic [$clog2(WIN_CYCLES+1)-1:0] win_reg;
  logic win_open_reg;
  logic [1:0] wait_reg;
  logic sel_changed, strap_rise, want_low, win_hit, win_expire;
  logic host_ok;

  ccm_sync2 #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({mode_strap_pin, addr_strap_pin, page_select_bit1_pin,
               page_select_bit0_pin}),
    .sync_out(pins_sync)
  );

  ccm_page_store #(.W(W), .PAGE0(PAGE0), .PAGE1(PAGE1), .PAGE2(PAGE2),
                   .PAGE3(PAGE3)) u_store (
    .clk_sys(clk_sys),
    .page_idx(load_page_reg),
    .page_data(rom_data)
  );

  assign strap_s = pins_sync[3];
  assign addr_s = pins_sync[2];
  assign sel1_s = pins_sync[1];
  assign sel0_s = pins_sync[0];
  assign sel_page = ccm_pkg::ccm_page_of(sel1_s, sel0_s);
  assign sel_changed = (sel_page != sel_prev_reg);
  assign strap_rise = strap_s & ~strap_prev_reg;
  // low power by request or idle with outputs off
  assign want_low = power_down_request |
                    (~idle_on_outputs_off_sel & outputs_disabled);
  assign win_hit = win_open_reg & strap_rise;
  assign win_expire = win_open_reg && (win_reg == '0);
  // host writes land only in bus mode and only in the run or low-power state
  assign host_ok = host_wr && (mode_reg == ccm_pkg::MODE_I2C) &&
                   ((state_reg == ccm_pkg::CCM_RUN) ||
                    (state_reg == ccm_pkg::CCM_LOWPWR));

  always_comb begin
    state_next = state_reg;
    load_page_next = load_page_reg;
    case (state_reg)
      ccm_pkg::CCM_BOOT: begin
        // strap decides which page seeds the registers
        if (wait_reg == ccm_pkg::BOOT_WAIT) begin
          state_next = ccm_pkg::CCM_LOAD;
          load_page_next = strap_s ? sel_page : ccm_pkg::PAGE_ZERO;
        end
      end
      ccm_pkg::CCM_LOAD: begin
        if (wait_reg == ccm_pkg::LOAD_DONE) begin
          state_next = ccm_pkg::CCM_RUN;
        end
      end
      ccm_pkg::CCM_RUN: begin
        if (win_hit) begin
          state_next = ccm_pkg::CCM_SETTLE;
          load_page_next = sel_page;
        end else if (want_low) begin
          state_next = ccm_pkg::CCM_LOWPWR;
        end
      end
      ccm_pkg::CCM_LOWPWR: begin
        if (!want_low) begin
          state_next = ccm_pkg::CCM_EXIT;
        end
      end
      ccm_pkg::CCM_EXIT: begin
        if (!strap_resample_inhibit && strap_s) begin
          state_next = ccm_pkg::CCM_LOAD;
          load_page_next = sel_page;
        end else if (!page0_reload_inhibit) begin
          state_next = ccm_pkg::CCM_LOAD;
          load_page_next = ccm_pkg::PAGE_ZERO;
        end else begin
          state_next = ccm_pkg::CCM_RUN;
        end
      end
      ccm_pkg::CCM_SETTLE: begin
        if (cnt_reg == '0) begin
          state_next = ccm_pkg::CCM_LOAD;
        end
      end
      default: begin
        state_next = ccm_pkg::CCM_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ccm_pkg::CCM_BOOT;
      load_page_reg <= ccm_pkg::PAGE_ZERO;
      wait_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      load_page_reg <= load_page_next;
      wait_reg <= (state_next != state_reg) ? 2'h0 : wait_reg + 2'h1;
    end
  end

  // mode and straps: sampled at power-up and at a resampling exit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_reg <= ccm_pkg::MODE_I2C;
      addr_reg <= 1'h0;
    end else if ((state_reg == ccm_pkg::CCM_BOOT) &&
                 (wait_reg == ccm_pkg::BOOT_WAIT)) begin
      mode_reg <= strap_s;
      addr_reg <= addr_s;
    end else if ((state_reg == ccm_pkg::CCM_EXIT) &&
                 !strap_resample_inhibit) begin
      mode_reg <= strap_s;
      addr_reg <= addr_s;
    end else if (win_hit && (state_reg == ccm_pkg::CCM_RUN)) begin
      mode_reg <= ccm_pkg::MODE_PAGE;
    end else if (win_expire && (state_reg == ccm_pkg::CCM_RUN)) begin
      mode_reg <= ccm_pkg::MODE_I2C; // window missed
    end
  end

  // active registers: page load or host write
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_reg <= '0;
      page_reg <= ccm_pkg::PAGE_ZERO;
    end else if ((state_reg == ccm_pkg::CCM_LOAD) &&
                 (wait_reg == ccm_pkg::LOAD_TAKE)) begin
      cfg_reg <= rom_data;
      page_reg <= load_page_reg;
    end else if (host_ok) begin
      cfg_reg <= host_wdata;
    end
  end

  // select-change window and settle counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sel_prev_reg <= ccm_pkg::PAGE_ZERO;
      strap_prev_reg <= 1'h0;
      win_open_reg <= 1'h0;
      win_reg <= '0;
      cnt_reg <= '0;
    end else begin
      sel_prev_reg <= sel_page;
      strap_prev_reg <= strap_s;
      if (state_reg != ccm_pkg::CCM_RUN || win_hit || win_expire) begin
        win_open_reg <= 1'h0;
      end else if (sel_changed && !win_open_reg &&
                   mode_reg == ccm_pkg::MODE_PAGE) begin
        // first select change opens the window
        win_open_reg <= 1'h1;
        win_reg <= WIN_CYCLES[$bits(win_reg)-1:0] - 1'b1;
      end else if (win_open_reg) begin
        win_reg <= win_reg - 1'b1;
      end
      if (state_next == ccm_pkg::CCM_SETTLE &&
          state_reg != ccm_pkg::CCM_SETTLE) begin
        cnt_reg <= SETTLE_CYCLES[$bits(cnt_reg)-1:0] - 1'b1;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign active_cfg = cfg_reg;
  assign mode_page = mode_reg;
  assign active_page = page_reg;
  assign addr_lsb = addr_reg;
  // bus lines only routed in bus mode
  assign bus_enable = (mode_reg == ccm_pkg::MODE_I2C);
  assign bus_scl_in = bus_enable ? sel0_s : 1'h1;
  assign bus_sda_in = bus_enable ? sel1_s : 1'h1;
  assign low_power = (state_reg == ccm_pkg::CCM_LOWPWR) ||
                     (state_reg == ccm_pkg::CCM_SETTLE);
  assign busy = (state_reg != ccm_pkg::CCM_RUN) &&
                (state_reg != ccm_pkg::CCM_LOWPWR);

  property p_load_page0;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_EXIT && strap_resample_inhibit &&
       !page0_reload_inhibit) |=> (load_page_reg == ccm_pkg::PAGE_ZERO);
  endproperty
  a_load_page0: assert property (p_load_page0)
    else $error("page 0 not chosen on exit");

  property p_keep;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_EXIT && strap_resample_inhibit &&
       page0_reload_inhibit) |=> (state_reg == ccm_pkg::CCM_RUN) &&
       $stable(cfg_reg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("registers changed with both inhibits");

  property p_lowpwr;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_RUN && power_down_request && !win_hit)
      |=> low_power;
  endproperty
  a_lowpwr: assert property (p_lowpwr)
    else $error("power-down not entered");

  property p_idle;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_RUN && !idle_on_outputs_off_sel &&
       outputs_disabled && !win_hit) |=> low_power;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle low power not entered");

  property p_bus;
    @(posedge clk_sys) disable iff (sys_rst)
      (mode_reg == ccm_pkg::MODE_PAGE) |-> !bus_enable && bus_scl_in;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus active in page mode");

  property p_bus_win;
    @(posedge clk_sys) disable iff (sys_rst)
      (mode_reg == ccm_pkg::MODE_I2C) |-> !win_open_reg;
  endproperty
  a_bus_win: assert property (p_bus_win)
    else $error("page window open in bus mode");

  property p_resample;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_EXIT && !strap_resample_inhibit &&
       strap_s) |=> mode_page ##2 (active_page == $past(load_page_reg, 1));
  endproperty
  a_resample: assert property (p_resample)
    else $error("resample to page mode failed");

  property p_boot;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_BOOT && wait_reg == ccm_pkg::BOOT_WAIT &&
       !strap_s) |=> (mode_page == ccm_pkg::MODE_I2C) ##3
      (active_page == ccm_pkg::PAGE_ZERO && active_cfg == PAGE0);
  endproperty
  a_boot: assert property (p_boot)
    else $error("bus mode boot not from page 0");

  property p_inh_mode;
    @(posedge clk_sys) disable iff (sys_rst)
      (state_reg == ccm_pkg::CCM_EXIT && strap_resample_inhibit)
      |=> $stable(mode_reg);
  endproperty
  a_inh_mode: assert property (p_inh_mode)
    else $error("mode changed with resample inhibited");
endmodule
`default_nettype wire

// ==== dv/ccm_host_model.sv ====
// host model: power-down request and register writes toward the controller
// assumes clk_sys is shared with the controller; drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module ccm_host_model (
  input wire logic clk_sys,
  output logic host_wr,
  output logic [63:0] host_wdata,
  output logic power_down_request
);
  initial begin
    host_wr = 1'h0;
    host_wdata = 64'h0;
    power_down_request = 1'h0;
  end

  // raised before the writes of a low-power cycle and cleared after them
  task automatic set_power_down(input logic v);
    @(negedge clk_sys);
    power_down_request = v;
  endtask

  // data inverted after the strobe so a stale word never looks valid
  task automatic write_word(input logic [63:0] d);
    @(negedge clk_sys);
    host_wr = 1'h1;
    host_wdata = d;
    @(negedge clk_sys);
    host_wr = 1'h0;
    host_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// testbench for the configuration and mode controller
// assumes the host model; short settle and window counts
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [63:0] P0 = 64'h0f0f_1111_2222_3333;
  localparam logic [63:0] P1 = 64'h1e1e_4444_5555_6666;
  localparam logic [63:0] P2 = 64'h2d2d_7777_8888_9999;
  localparam logic [63:0] P3 = 64'h3c3c_aaaa_bbbb_cccc;
  logic [63:0] pg [4] = '{P0, P1, P2, P3};
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic strap = 1'h0, addr = 1'h1, sel0 = 1'h0, sel1 = 1'h0;
  logic idle_sel = 1'h1, rl_inh = 1'h1, rs_inh = 1'h1, outs_off = 1'h0;
  logic host_wr, pd_req, mode, alsb, ben, scl, sda, lp, busy;
  logic [63:0] wdata, cfg, d, m_cfg;
  logic [1:0] page;
  int n_fail = 0, checked = 0, s, s2, k;
  // model of the active set: mode, loaded page and register word
  int m_mode = 0, m_page = 0;

  always #25 clk_sys = ~clk_sys;

  ccm_host_model ccm_host_model_inst (.clk_sys(clk_sys), .host_wr(host_wr),
    .host_wdata(wdata), .power_down_request(pd_req));

  ccm_ctrl #(.SETTLE_CYCLES(20), .WIN_CYCLES(10), .PAGE0(P0), .PAGE1(P1),
    .PAGE2(P2), .PAGE3(P3)) ccm_ctrl_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .mode_strap_pin(strap), .addr_strap_pin(addr),
    .page_select_bit0_pin(sel0), .page_select_bit1_pin(sel1),
    .host_wr(host_wr), .host_wdata(wdata), .power_down_request(pd_req),
    .idle_on_outputs_off_sel(idle_sel), .page0_reload_inhibit(rl_inh),
    .strap_resample_inhibit(rs_inh), .outputs_disabled(outs_off),
    .active_cfg(cfg), .mode_page(mode), .active_page(page),
    .addr_lsb(alsb), .bus_enable(ben), .bus_scl_in(scl), .bus_sda_in(sda),
    .low_power(lp), .busy(busy));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    int i;
    repeat (8) @(negedge clk_sys);
    for (i = 0; i < 400 && busy !== 1'h0; i++) @(negedge clk_sys);
    chk({63'h0, busy}, 64'h0);
    chk(cfg, m_cfg);
    chk({63'h0, mode}, 64'(m_mode));
    chk({62'h0, page}, 64'(m_page));
  endtask

  task automatic boot(input logic st, input int p);
    @(negedge clk_sys);
    sys_rst = 1'h1;
    strap = st;
    {sel1, sel0} = p[1:0];
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'h0;
    m_mode = int'(st);
    m_page = st ? p : 0;
    m_cfg = pg[m_page];
    settle();
  endtask

  task automatic lp_cycle(input logic rl, input logic rs, input logic wr,
                          input logic [63:0] dw);
    rl_inh = rl;
    rs_inh = rs;
    ccm_host_model_inst.set_power_down(1'h1);
    repeat (3) @(negedge clk_sys);
    chk({63'h0, lp}, 64'h1);
    if (wr) ccm_host_model_inst.write_word(dw);
    ccm_host_model_inst.set_power_down(1'h0);
    // model: bus-mode write, then the exit choice of the two inhibits
    if (wr && m_mode == 0) m_cfg = dw;
    if (!rs) m_mode = int'(strap);
    if (!rs && strap) m_page = int'({sel1, sel0});
    else if (!rl) m_page = 0;
    if ((!rs && strap) || !rl) m_cfg = pg[m_page];
    settle();
    chk({63'h0, lp}, 64'h0);
  endtask

  initial begin
    #(50 * 20000);
    n_fail++;
    summarize();
  end

  initial begin
    s = $urandom(32'ha35f44dd);
    s = $urandom_range(3);
    s2 = (s + 1) % 4;
    boot(1'h0, s);
    chk({63'h0, mode}, 64'h0);
    chk(cfg, P0);
    chk({63'h0, ben}, 64'h1);
    chk({63'h0, alsb}, 64'h1);
    {sel1, sel0} = 2'h1;
    repeat (4) @(negedge clk_sys);
    chk({62'h0, sda, scl}, 64'h1);
    {sel1, sel0} = 2'h2;
    repeat (4) @(negedge clk_sys);
    chk({62'h0, sda, scl}, 64'h2);
    d = {$urandom, $urandom};
    lp_cycle(1'h1, 1'h1, 1'h1, d);
    chk(cfg, d);
    lp_cycle(1'h0, 1'h1, 1'h0, d);
    chk(cfg, P0);
    d = {$urandom, $urandom};
    lp_cycle(1'h1, 1'h0, 1'h1, d);
    chk(cfg, d);
    chk({63'h0, mode}, 64'h0);
    strap = 1'h1;
    {sel1, sel0} = s[1:0];
    lp_cycle(1'h1, 1'h0, 1'h0, d);
    chk(cfg, pg[s]);
    chk({63'h0, mode}, 64'h1);
    ccm_host_model_inst.write_word(~d);
    repeat (2) @(negedge clk_sys);
    chk(cfg, pg[s]);
    strap = 1'h0;
    repeat (5) @(negedge clk_sys);
    {sel1, sel0} = s2[1:0];
    repeat (2) @(negedge clk_sys);
    strap = 1'h1;
    repeat (8) @(negedge clk_sys);
    chk({63'h0, lp}, 64'h1);
    m_page = s2;
    m_cfg = pg[s2];
    settle();
    chk(cfg, pg[s2]);
    chk({62'h0, page}, 64'(s2));
    strap = 1'h0;
    repeat (5) @(negedge clk_sys);
    {sel1, sel0} = s2[1:0] ^ 2'h1;
    repeat (40) @(negedge clk_sys);
    chk({63'h0, mode}, 64'h0);
    m_mode = 0;
    settle();
    outs_off = 1'h1;
    repeat (4) @(negedge clk_sys);
    chk({63'h0, lp}, 64'h0);
    idle_sel = 1'h0;
    repeat (4) @(negedge clk_sys);
    chk({63'h0, lp}, 64'h1);
    outs_off = 1'h0;
    idle_sel = 1'h1;
    settle();
    // strap low, reload allowed: back to page 0 in bus mode
    lp_cycle(1'h0, 1'h0, 1'h0, d);
    chk(cfg, P0);
    chk({63'h0, mode}, 64'h0);
    // every page code after all writes: store contents unchanged
    for (k = 0; k < 4; k++) begin
      boot(1'h1, k);
      chk({63'h0, mode}, 64'h1);
      chk(cfg, pg[k]);
      chk({62'h0, page}, 64'(k));
    end
    summarize();
  end
endmodule
`default_nettype wire
